// ===== core/csb_regs.svh
// register offsets, field positions, frame shape and reset values for the serial slave
`ifndef CSB_REGS_SVH
`define CSB_REGS_SVH

// wishbone address width and word offsets (byte addresses)
`define CSB_AW 4
`define CSB_OFS_CTRL 4'h0
`define CSB_OFS_DATA 4'h4
`define CSB_OFS_STAT 4'h8

// control register fields
`define CSB_CTRL_START 0
`define CSB_CTRL_STOP 1

// status register fields
`define CSB_STAT_OVR 0
`define CSB_STAT_RXFULL 1
`define CSB_STAT_RUN 2
`define CSB_STAT_BUSY 3
`define CSB_STAT_TXLD 4

// frame shape and reset values
`define CSB_FRAME_BITS 8
`define CSB_CNT_LAST 3'h7
`define CSB_SO_IDLE 1'b1
`define CSB_BUF_RST 8'h00
`define CSB_WORD_ZERO 32'h0000_0000

`endif

// ===== core/csb_pkg.sv
// types shared by the serial slave design and its bench
package csb_pkg;

    // wishbone request from the master
    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [3:0] adr;
        logic [3:0] sel;
        logic [31:0] dat;
    } csb_wb_req_t;

    // wishbone answer to the master
    typedef struct packed {
        logic ack;
        logic [31:0] dat;
    } csb_wb_rsp_t;

    // channel control states
    typedef enum logic [1:0] {
        CSB_ST_STOP,
        CSB_ST_WAIT_TX,
        CSB_ST_READY,
        CSB_ST_END
    } csb_state_t;

endpackage

// ===== core/csb_sync.sv
// two flip-flop level synchroniser into the system clock domain
`timescale 1ns/1ps
module csb_sync (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // level in and out
    input wire logic d_i,
    output logic q_o
);
    logic meta_reg;
    logic meta_next;
    logic q_reg;
    logic q_next;

    // first stage feeds only the second
    always_comb
    begin
        meta_next = d_i;
        q_next = meta_reg;
    end

    // register both stages
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            meta_reg <= 1'b0;
            q_reg <= 1'b0;
        end
        else
        begin
            meta_reg <= meta_next;
            q_reg <= q_next;
        end
    end

    assign q_o = q_reg;
endmodule

// ===== core/csb_shift.sv
// shift engine on the master's serial clock, msb first, drive on fall, sample on rise
`timescale 1ns/1ps
`include "csb_regs.svh"
module csb_shift (
    // link clock and hold-off reset from the system domain
    input wire logic sclk_i,
    input wire logic arst_i,
    // serial pins
    input wire logic sdi_i,
    output logic sdo_o,
    // words to and from the system domain
    input wire logic [7:0] tx_i,
    output logic [7:0] rx_o,
    output logic done_tgl_o
);
    logic [2:0] cnt_reg;
    logic [2:0] cnt_next;
    logic [7:0] sh_reg;
    logic [7:0] sh_next;
    logic [7:0] rx_reg;
    logic [7:0] rx_next;
    logic tgl_reg;
    logic tgl_next;
    logic so_reg;
    logic so_next;

    // sample side: shift in on rising edge, eight bits close a frame
    always_comb
    begin
        sh_next = {sh_reg[6:0], sdi_i};
        cnt_next = cnt_reg + 3'h1;
        rx_next = rx_reg;
        tgl_next = tgl_reg;
        if (cnt_reg == `CSB_CNT_LAST)
        begin
            rx_next = {sh_reg[6:0], sdi_i};
            tgl_next = ~tgl_reg;
        end
    end

    // rising edge registers; held cleared while the channel is stopped
    always_ff @(posedge sclk_i or posedge arst_i)
    begin
        if (arst_i)
        begin
            cnt_reg <= 3'h0;
            sh_reg <= `CSB_BUF_RST;
            rx_reg <= `CSB_BUF_RST;
            tgl_reg <= 1'b0;
        end
        else
        begin
            cnt_reg <= cnt_next;
            sh_reg <= sh_next;
            rx_reg <= rx_next;
            tgl_reg <= tgl_next;
        end
    end

    // drive side: next bit, msb first, picked by the bit count
    always_comb
    begin
        so_next = tx_i[3'h7 - cnt_reg];
    end

    // falling edge changes the output; idles high out of reset
    always_ff @(negedge sclk_i or posedge arst_i)
    begin
        if (arst_i)
            so_reg <= `CSB_SO_IDLE;
        else
            so_reg <= so_next;
    end

    assign sdo_o = so_reg;
    assign rx_o = rx_reg;
    assign done_tgl_o = tgl_reg;
endmodule

// ===== core/csb_top.sv
// clocked serial slave channel with busy handshake and wishbone registers
//
// Contract
// - the channel works as a serial slave in single transfers of 8-bit frames.
// - the channel uses clock and data phase type 1.
// - the serial clock is only an input from the master and is never driven.
// - data arrives on the data input pin and leaves on the separate data output pin.
// - the data output is enabled and rests at 1 before the first transfer.
// - a transfer-end interrupt is raised after every completed frame; here only for frames that end in the ready state and not during a stop write.
// - the transmit byte is loaded into the data buffer before ready is signalled.
// - busy low tells the master that a transfer may start.
// - after the transfer-end interrupt the received byte is kept and busy is raised.
// - busy high means the slave cannot accept a transfer until it falls again.
// - at frame end the shift contents move to the data buffer, then the interrupt fires.
// - status bit 0 flags overrun when a frame ends before the last byte was read.
// - writing 1 to start bit 0 starts the channel into communication standby.
//
// Design decisions made here: the Wishbone register port and the register offsets.
`timescale 1ns/1ps
`include "csb_regs.svh"
module csb_top (
    // system clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // wishbone slave
    input wire csb_pkg::csb_wb_req_t wb_req_i,
    output csb_pkg::csb_wb_rsp_t wb_rsp_o,
    // serial link
    input wire logic serial_clock_in_i,
    input wire logic serial_data_in_i,
    output logic serial_data_out_o,
    // handshake and event
    output logic busy_o,
    output logic transfer_end_interrupt_o
);
    import csb_pkg::*;

    csb_state_t state_reg;
    csb_state_t state_next;
    logic busy_reg;
    logic busy_next;
    logic end_reg;
    logic end_next;
    logic link_rst_reg;
    logic link_rst_next;
    logic [7:0] buf_reg;
    logic [7:0] buf_next;
    logic txld_reg;
    logic txld_next;
    logic rxfull_reg;
    logic rxfull_next;
    logic ovr_reg;
    logic ovr_next;
    logic ack_reg;
    logic ack_next;
    logic [31:0] rdat_reg;
    logic [31:0] rdat_next;
    logic tgl_seen_reg;
    logic tgl_seen_next;
    logic [7:0] rx_word;
    logic done_tgl;
    logic tgl_sync;
    logic done_evt;
    logic take;
    logic wr_ctrl;
    logic wr_data;
    logic wr_stat;
    logic rd_data;

    // address match helper
    function automatic logic hit(input logic [3:0] adr, input logic [3:0] ofs);
        hit = (adr == ofs);
    endfunction

    // link-side shift engine; the serial clock is only ever an input
    csb_shift u_shift (
        .sclk_i(serial_clock_in_i),
        .arst_i(link_rst_reg),
        .sdi_i(serial_data_in_i),
        .sdo_o(serial_data_out_o),
        .tx_i(buf_reg),
        .rx_o(rx_word),
        .done_tgl_o(done_tgl)
    );

    // frame-done toggle crosses into the system domain
    csb_sync u_sync (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .d_i(done_tgl),
        .q_o(tgl_sync)
    );

    // bus decode: one request taken per cycle without a pending ack
    always_comb
    begin
        take = wb_req_i.cyc && wb_req_i.stb && !ack_reg;
        wr_ctrl = take && wb_req_i.we && wb_req_i.sel[0] && hit(wb_req_i.adr, `CSB_OFS_CTRL);
        wr_data = take && wb_req_i.we && wb_req_i.sel[0] && hit(wb_req_i.adr, `CSB_OFS_DATA);
        wr_stat = take && wb_req_i.we && wb_req_i.sel[0] && hit(wb_req_i.adr, `CSB_OFS_STAT);
        rd_data = take && !wb_req_i.we && hit(wb_req_i.adr, `CSB_OFS_DATA);
        done_evt = (tgl_sync != tgl_seen_reg) && (state_reg == CSB_ST_READY);
        tgl_seen_next = tgl_sync;
    end

    // channel state: stop, wait for tx byte, ready, frame end
    always_comb
    begin
        state_next = state_reg;
        case (state_reg)
            CSB_ST_STOP:
            begin
                if (wr_ctrl && wb_req_i.dat[`CSB_CTRL_START])
                    state_next = CSB_ST_WAIT_TX;
            end
            CSB_ST_WAIT_TX:
            begin
                if (txld_reg)
                    state_next = CSB_ST_READY;
            end
            CSB_ST_READY:
            begin
                if (done_evt)
                    state_next = CSB_ST_END;
            end
            CSB_ST_END:
            begin
                state_next = CSB_ST_WAIT_TX;
            end
            default:
            begin
                state_next = CSB_ST_STOP;
            end
        endcase
        if (wr_ctrl && wb_req_i.dat[`CSB_CTRL_STOP])
            state_next = CSB_ST_STOP;
    end

    // handshake outputs follow the next state
    always_comb
    begin
        busy_next = !(state_next == CSB_ST_READY || state_next == CSB_ST_END);
        end_next = (state_reg == CSB_ST_READY) && (state_next == CSB_ST_END);
        link_rst_next = (state_next == CSB_ST_STOP);
    end

    // data buffer, tx-loaded, receive-full and overrun flags
    always_comb
    begin
        buf_next = buf_reg;
        txld_next = txld_reg;
        rxfull_next = rxfull_reg;
        ovr_next = ovr_reg;
        if (rd_data)
            rxfull_next = 1'b0;
        if (wr_stat && wb_req_i.dat[`CSB_STAT_OVR])
            ovr_next = 1'b0;
        if (wr_data)
        begin
            buf_next = wb_req_i.dat[7:0];
            txld_next = 1'b1;
        end
        if (done_evt)
        begin
            buf_next = rx_word;
            txld_next = 1'b0;
            rxfull_next = 1'b1;
            if (rxfull_reg)
                ovr_next = 1'b1;
        end
    end

    // bus answer: ack one cycle after the request, unmapped reads give zero
    always_comb
    begin
        ack_next = take;
        rdat_next = rdat_reg;
        if (take)
        begin
            rdat_next = `CSB_WORD_ZERO;
            if (hit(wb_req_i.adr, `CSB_OFS_DATA))
                rdat_next[7:0] = buf_reg;
            else if (hit(wb_req_i.adr, `CSB_OFS_STAT))
            begin
                rdat_next[`CSB_STAT_OVR] = ovr_reg;
                rdat_next[`CSB_STAT_RXFULL] = rxfull_reg;
                rdat_next[`CSB_STAT_RUN] = (state_reg != CSB_ST_STOP);
                rdat_next[`CSB_STAT_BUSY] = busy_reg;
                rdat_next[`CSB_STAT_TXLD] = txld_reg;
            end
        end
    end

    // register all state
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            state_reg <= CSB_ST_STOP;
            busy_reg <= 1'b1;
            end_reg <= 1'b0;
            link_rst_reg <= 1'b1;
            buf_reg <= `CSB_BUF_RST;
            txld_reg <= 1'b0;
            rxfull_reg <= 1'b0;
            ovr_reg <= 1'b0;
            ack_reg <= 1'b0;
            rdat_reg <= `CSB_WORD_ZERO;
            tgl_seen_reg <= 1'b0;
        end
        else
        begin
            state_reg <= state_next;
            busy_reg <= busy_next;
            end_reg <= end_next;
            link_rst_reg <= link_rst_next;
            buf_reg <= buf_next;
            txld_reg <= txld_next;
            rxfull_reg <= rxfull_next;
            ovr_reg <= ovr_next;
            ack_reg <= ack_next;
            rdat_reg <= rdat_next;
            tgl_seen_reg <= tgl_seen_next;
        end
    end

    // top outputs straight from flops
    assign busy_o = busy_reg;
    assign transfer_end_interrupt_o = end_reg;
    assign wb_rsp_o.ack = ack_reg;
    assign wb_rsp_o.dat = rdat_reg;

    // checks on the system clock domain
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    a_busy_after_end: assert property (
        end_reg && !link_rst_next |=> busy_reg && !end_reg)
        else $error("busy did not rise after transfer end");
    a_end_single_pulse: assert property (
        done_evt && !(wr_ctrl && wb_req_i.dat[`CSB_CTRL_STOP]) |=> end_reg ##1 !end_reg)
        else $error("transfer end not a single pulse after frame");
    a_buf_before_end: assert property (
        $rose(end_reg) |-> buf_reg == $past(rx_word) && rxfull_reg)
        else $error("buffer not loaded with received byte at transfer end");
    a_ready_needs_tx: assert property (
        $fell(busy_reg) |-> txld_reg && state_reg == CSB_ST_READY)
        else $error("busy fell without a loaded transmit byte");
    a_busy_low_ready: assert property (
        state_reg == CSB_ST_WAIT_TX && txld_reg && !wr_ctrl |=> !busy_reg)
        else $error("busy not lowered when channel ready");
    a_stopped_busy: assert property (
        state_reg == CSB_ST_STOP |-> busy_reg && link_rst_reg)
        else $error("stopped channel not busy");
    a_overrun_set: assert property (
        done_evt && rxfull_reg |=> ovr_reg ##1 (ovr_reg || $past(wr_stat && wb_req_i.dat[`CSB_STAT_OVR])))
        else $error("overrun flag not set on unread byte");
    a_start_trig: assert property (
        state_reg == CSB_ST_STOP && wr_ctrl && wb_req_i.dat[`CSB_CTRL_START]
        && !wb_req_i.dat[`CSB_CTRL_STOP] |=> state_reg == CSB_ST_WAIT_TX && busy_reg)
        else $error("start trigger did not enter standby");
    a_idle_out_high: assert property (
        link_rst_reg && $past(link_rst_reg) |-> serial_data_out_o == `CSB_SO_IDLE)
        else $error("data output not idle high while stopped");
    a_wb_ack_once: assert property (
        take |=> ack_reg ##1 !ack_reg)
        else $error("bus ack not a single cycle");

    // status flags, standby and stop; a frame end beats a clear in the same cycle
    a_tx_held_ready: assert property (
        state_reg == CSB_ST_READY |-> txld_reg)
        else $error("ready without a loaded transmit byte");
    a_irq_while_ready: assert property (
        end_reg |-> !busy_reg && state_reg == CSB_ST_END)
        else $error("transfer end outside the frame end state");
    a_wait_is_busy: assert property (
        state_reg == CSB_ST_WAIT_TX |-> busy_reg)
        else $error("busy low while waiting for a transmit byte");
    a_rx_full_set: assert property (
        done_evt |=> rxfull_reg)
        else $error("receive full not set at frame end");
    a_read_clears: assert property (
        rd_data && !done_evt |=> !rxfull_reg)
        else $error("data read did not clear receive full");
    a_ovr_held: assert property (
        ovr_reg && !(wr_stat && wb_req_i.dat[`CSB_STAT_OVR]) |=> ovr_reg)
        else $error("overrun flag dropped without a clear");
    a_ovr_cleared: assert property (
        wr_stat && wb_req_i.dat[`CSB_STAT_OVR] && !(done_evt && rxfull_reg) |=> !ovr_reg)
        else $error("overrun flag not cleared by write");
    a_stop_wins: assert property (
        wr_ctrl && wb_req_i.dat[`CSB_CTRL_STOP] |=> state_reg == CSB_ST_STOP && busy_reg)
        else $error("stop request did not stop the channel");

    // main scenarios
    c_frame_done: cover property (end_reg ##[1:30] !busy_reg);
    c_overrun: cover property (done_evt && rxfull_reg);
    c_start_ready: cover property ($rose(state_reg == CSB_ST_WAIT_TX) ##[1:20] $fell(busy_reg));
    c_ovr_clear: cover property (wr_stat && wb_req_i.dat[`CSB_STAT_OVR] && ovr_reg);
    c_stop_run: cover property (state_reg != CSB_ST_STOP ##1 state_reg == CSB_ST_STOP);
endmodule

// ===== test/csb_master_model.sv
// serial master model that clocks one frame at a time once the slave is ready
`timescale 1ns/1ps
module csb_master_model (
    // handshake and data from the slave
    input wire logic busy_i,
    input wire logic sdo_i,
    // clock and data to the slave
    output logic sclk_o,
    output logic sdi_o
);
    // clock idles high and stands still between frames
    initial
    begin
        sclk_o = 1'b1;
        sdi_o = 1'b0;
    end

    // one frame: data changes on the fall, sampled on the rise, msb first
    task automatic frame(input logic [7:0] mtx, output logic [7:0] srx);
        int i;
        wait (busy_i === 1'b0);
        #37;
        for (i = 7; i >= 0; i--)
        begin
            sclk_o = 1'b0;
            sdi_o = mtx[i];
            #62.5;
            sclk_o = 1'b1;
            srx[i] = sdo_i;
            #62.5;
        end
        // released line has no pull, so it must not keep the last bit
        sdi_o = ~sdi_o;
    endtask
endmodule

// ===== test/testbench.sv
// self-checking bench for the clocked serial slave channel
`timescale 1ns/1ps
`include "csb_regs.svh"
module testbench;
    import csb_pkg::*;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    csb_wb_req_t wb_req = '0;
    csb_wb_rsp_t wb_rsp;
    logic sclk, sdi, sdo, busy, irq;
    int err_total = 0;
    int total_checks = 0;
    int irq_cnt = 0;
    logic [31:0] exp_q[$];
    logic [15:0] lfsr = 16'hea01;
    logic [7:0] mtx, srx, stx;
    int k, n0, n;

    csb_top csb_top_inst (.clk_i(clk_i), .rst_i(rst_i), .wb_req_i(wb_req), .wb_rsp_o(wb_rsp),
        .serial_clock_in_i(sclk), .serial_data_in_i(sdi), .serial_data_out_o(sdo),
        .busy_o(busy), .transfer_end_interrupt_o(irq));
    csb_master_model csb_master_model_inst (.busy_i(busy), .sdo_i(sdo), .sclk_o(sclk),
        .sdi_o(sdi));

    // system clock
    always #50 clk_i = ~clk_i;

    function automatic logic [15:0] lfsr_next(input logic [15:0] x);
        return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
    endfunction

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            err_total++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // classic single cycle, held until ack is sampled, then released
    task automatic wb_cycle(input logic we, input logic [3:0] adr, input logic [31:0] dat);
        @(posedge clk_i);
        wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: 4'hf, dat: dat};
        // wait for the answer however long it takes; only the watchdog ends a hang
        do
        begin
            @(posedge clk_i);
        end while (wb_rsp.ack !== 1'b1);
        wb_req <= '0;
    endtask

    task automatic wb_read(input logic [3:0] adr, input logic [31:0] exp);
        exp_q.push_back(exp);
        wb_cycle(1'b0, adr, 32'h0000_0000);
    endtask

    task automatic wait_busy(input logic lvl);
        int c;
        c = 0;
        while (busy !== lvl && c < 12)
        begin
            @(posedge clk_i);
            c++;
        end
    endtask

    task automatic stop_test();
        $display("checks %0d errors %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // take the oldest note when a read is acknowledged, count interrupt pulses
    always @(posedge clk_i)
    begin
        if (wb_rsp.ack === 1'b1 && wb_req.we === 1'b0 && exp_q.size() > 0)
            check("read data", wb_rsp.dat, exp_q.pop_front());
        if (irq === 1'b1)
            irq_cnt++;
    end

    // watchdog against a hung handshake
    initial
    begin
        #3_000_000;
        err_total++;
        stop_test();
    end

    // main sequence
    initial
    begin
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        #1;
        check("busy at reset", 32'(busy), 32'h0000_0001);
        check("output idle", 32'(sdo), 32'(`CSB_SO_IDLE));
        wb_read(`CSB_OFS_STAT, 32'h0000_0008);
        wb_cycle(1'b1, `CSB_OFS_CTRL, 32'h0000_0001);
        wb_read(`CSB_OFS_STAT, 32'h0000_000c);
        repeat (4) @(posedge clk_i);
        check("busy before load", 32'(busy), 32'h0000_0001);
        check("output before frame", 32'(sdo), 32'h0000_0001);
        for (k = 0; k < 4; k++)
        begin
            stx = lfsr[7:0];
            lfsr = lfsr_next(lfsr);
            mtx = lfsr[15:8];
            lfsr = lfsr_next(lfsr);
            wb_cycle(1'b1, `CSB_OFS_DATA, {24'h00_0000, stx});
            wait_busy(1'b0);
            check("busy after load", 32'(busy), 32'h0000_0000);
            n0 = irq_cnt;
            csb_master_model_inst.frame(mtx, srx);
            check("slave to master", 32'(srx), 32'(stx));
            n = 0;
            while (irq_cnt == n0 && n < 12)
            begin
                @(posedge clk_i);
                n++;
            end
            check("interrupt count", 32'(irq_cnt), 32'(n0 + 1));
            repeat (2) @(posedge clk_i);
            check("busy after frame", 32'(busy), 32'h0000_0001);
            // third frame is left unread so the fourth one overruns
            if (k != 2)
                wb_read(`CSB_OFS_DATA, {24'h00_0000, mtx});
            wb_read(`CSB_OFS_STAT, (k == 2) ? 32'h0000_000e :
                (k == 3) ? 32'h0000_000d : 32'h0000_000c);
        end
        wb_cycle(1'b1, `CSB_OFS_STAT, 32'h0000_0001);
        wb_read(`CSB_OFS_STAT, 32'h0000_000c);
        wb_read(4'hc, 32'h0000_0000);
        wb_cycle(1'b1, `CSB_OFS_CTRL, 32'h0000_0002);
        wb_read(`CSB_OFS_STAT, 32'h0000_0008);
        repeat (3) @(posedge clk_i);
        check("output when stopped", 32'(sdo), 32'(`CSB_SO_IDLE));
        check("interrupt total", 32'(irq_cnt), 32'h0000_0004);
        check("reads answered", 32'(exp_q.size()), 32'h0000_0000);
        stop_test();
    end
endmodule
